// ### hw/tcr_region.sv
// tcr_region: region, size and enable register of the primary tight memory,
// the read-as-zero selection register, and the address window decode
// assumes requests come from core logic on core_clk_i; both strap pins are static
// but asynchronous to the core clock, so they are synchronised before use
//
// Operation
// - The region register is read and written only from privileged mode.
// - Bits 31:12 of the region register hold the writable base address.
// - Base bits from log2(size)-1 down to 12 are ignored in the window decode.
// - After reset the base is implementation-defined if the low select pin is 0, else zero.
// - Bits 11:7 and bit 1 are reserved; they read as zero here and writes must hold zero.
// - The size field in bits 6:2 returns the configured size and ignores writes.
// - Size codes are 0 for none and 3 for 4KB, doubling per step up to 14 for 8MB.
// - Bit 0 enables the memory when 1 and disables it when 0.
// - The enable bit resets to the level of the initial enable pin.
// - Without the memory the enable bit always reads zero.
// - The region register answers crn 9, crm 1, opcode1 0, opcode2 1.
// - The selection register reads zero and ignores writes.
// - The selection register is reached only from privileged mode.
`default_nettype none

module tcr_region
  import tcr_pkg::*;
#(
  parameter logic [4:0]  SIZE_CODE   = SIZE_4KB,
  parameter logic        MEM_PRESENT = 1'b1,
  parameter logic [19:0] IMPL_BASE   = RST_BASE_IMPL
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // static configuration pins
  input  wire logic        low_address_select_pin_i,
  input  wire logic        initial_enable_pin_i,
  // coprocessor access
  input  wire tcr_cp_req_t cp_req_i,
  output logic             cp_ready_o,
  output tcr_cp_rsp_t      cp_rsp_o,
  // memory window decode
  input  wire logic        mem_valid_i,
  input  wire logic [31:0] mem_addr_i,
  output logic             mem_hit_o,
  // region state to the memory path
  output logic [19:0]      tcm_base_o,
  output logic             tcm_enable_o
);

  // memory counts as absent if built without it or with a zero size
  localparam logic PRESENT = MEM_PRESENT && (SIZE_CODE != SIZE_NONE);
  // log2 of the window size in bytes; the window checks use it instead of the mask
  localparam int   WIN_SHIFT = int'(SIZE_CODE) - int'(SIZE_LOG_OFS) + BASE_LSB;

  // register state
  tcr_state_t   state;
  tcr_state_t   next_state;
  logic [19:0]  base;
  logic [19:0]  next_base;
  logic         en;
  logic         next_en;
  tcr_cp_rsp_t  rsp;
  tcr_cp_rsp_t  next_rsp;
  logic         hit;
  logic         next_hit;

  // strap synchronisers
  logic         low_meta;
  logic         low_sync;
  logic         ien_meta;
  logic         ien_sync;

  // decode helpers
  logic [19:0]  cmp_mask;
  logic         take;
  logic [31:0]  read_word;

  // true for the region register encoding
  function automatic logic is_region(input tcr_cp_req_t r);
    is_region = (r.crn == CRN_REGION) && (r.crm == CRM_REGION) &&
                (r.op1 == OP1_REGION) && (r.op2 == OP2_REGION);
  endfunction

  // true for the selection register encoding
  function automatic logic is_select(input tcr_cp_req_t r);
    is_select = (r.crn == CRN_REGION) && (r.crm == CRM_SELECT) &&
                (r.op1 == OP1_REGION) && (r.op2 == OP2_SELECT);
  endfunction

  // pins are static but unrelated to the core clock; the first stage feeds only
  // the second, and the strap load waits until the second stage has settled
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_meta <= 1'b0;
      low_sync <= 1'b0;
      ien_meta <= 1'b0;
      ien_sync <= 1'b0;
    end else begin
      low_meta <= low_address_select_pin_i;
      low_sync <= low_meta;
      ien_meta <= initial_enable_pin_i;
      ien_sync <= ien_meta;
    end
  end

  // base bits at or above log2(size) take part in the compare, lower ones are
  // ignored so a misaligned base still decodes to the aligned window
  generate
    for (genvar k = 0; k < 20; k++) begin : g_mask
      assign cmp_mask[k] = (5'(k) + SIZE_LOG_OFS) >= SIZE_CODE;
    end
  endgenerate

  // word returned for a region read; reserved bits read as zero
  always_comb begin
    read_word                          = '0;
    read_word[BASE_MSB:BASE_LSB]       = base;
    read_word[SIZE_MSB:SIZE_LSB]       = PRESENT ? SIZE_CODE : SIZE_NONE;
    read_word[ENABLE_BIT]              = en;
  end

  // a request is taken only once the straps are loaded
  assign take       = cp_req_i.valid && (state == ST_RUN);
  assign cp_ready_o = (state == ST_RUN);

  // next-state logic for init sequence, region state, answer and decode
  always_comb begin
    next_state = state;
    next_base  = base;
    next_en    = en;
    next_rsp   = '0;
    next_hit   = 1'b0;
    case (state)
      ST_SYNC0: begin
        next_state = ST_SYNC1;
      end
      ST_SYNC1: begin
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        // straps are sampled once, after the synchronisers have filled
        next_state = ST_RUN;
        next_base  = low_sync ? RST_BASE_LOW : IMPL_BASE;
        next_en    = ien_sync && PRESENT;
      end
      ST_RUN: begin
        if (take) begin
          next_rsp.ack = 1'b1;
          if (!cp_req_i.priv) begin
            next_rsp.undef = 1'b1;
          end else if (is_region(cp_req_i)) begin
            if (cp_req_i.write) begin
              // size and reserved bits are dropped on write
              next_base = cp_req_i.wdata[BASE_MSB:BASE_LSB];
              next_en   = cp_req_i.wdata[ENABLE_BIT] && PRESENT;
            end else begin
              next_rsp.rdata = read_word;
            end
          end else if (is_select(cp_req_i)) begin
            next_rsp.rdata = '0;
          end else begin
            next_rsp.undef = 1'b1;
          end
        end
        // window decode uses the base as it stands this cycle
        next_hit = mem_valid_i && en &&
                   (((mem_addr_i[BASE_MSB:BASE_LSB] ^ base) & cmp_mask) == '0);
      end
      default: begin
        next_state = ST_SYNC0;
      end
    endcase
  end

  // registers only
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_SYNC0;
      base  <= RST_BASE_LOW;
      en    <= RST_ENABLE;
      rsp   <= '0;
      hit   <= 1'b0;
    end else begin
      state <= next_state;
      base  <= next_base;
      en    <= next_en;
      rsp   <= next_rsp;
      hit   <= next_hit;
    end
  end

  // outputs straight from flip-flops
  assign cp_rsp_o     = rsp;
  assign mem_hit_o    = hit;
  assign tcm_base_o   = base;
  assign tcm_enable_o = en;

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // user-mode access to either register is refused and changes nothing
  AST_USER_REFUSED: assert property (
    take && !cp_req_i.priv |=> rsp.ack && rsp.undef && rsp.rdata == '0 && $stable(base)
  ) else $error("user mode access was not refused");

  // a privileged write lands in the base field on the next edge
  AST_BASE_WRITE: assert property (
    take && cp_req_i.priv && cp_req_i.write && is_region(cp_req_i)
    |=> base == $past(cp_req_i.wdata[BASE_MSB:BASE_LSB])
  ) else $error("base address write not stored");

  // without a privileged region write the base never moves once running
  AST_BASE_HOLD: assert property (
    state == ST_RUN && !(take && cp_req_i.priv && cp_req_i.write && is_region(cp_req_i))
    |=> $stable(base) && $stable(en)
  ) else $error("region state changed without a write");

  // strap load of the base follows the low select pin
  AST_STRAP_BASE: assert property (
    state == ST_LOAD |=> base == ($past(low_sync) ? RST_BASE_LOW : IMPL_BASE)
  ) else $error("base reset value does not follow the select pin");

  // strap load of the enable follows the initial enable pin
  AST_STRAP_EN: assert property (
    state == ST_LOAD |=> en == ($past(ien_sync) && PRESENT)
  ) else $error("enable reset value does not follow the pin");

  // the init sequence takes exactly three edges after reset release
  AST_INIT_LEN: assert property (
    state == ST_SYNC0 |=> state == ST_SYNC1 ##1 state == ST_LOAD ##1 state == ST_RUN
  ) else $error("strap load sequence has wrong length");

  // a region read shows the size code and zero reserved bits
  AST_READ_FIELDS: assert property (
    take && cp_req_i.priv && !cp_req_i.write && is_region(cp_req_i)
    |=> rsp.rdata[SIZE_MSB:SIZE_LSB] == (PRESENT ? SIZE_CODE : SIZE_NONE) &&
        rsp.rdata[RSVD_HI_MSB:RSVD_HI_LSB] == '0 && !rsp.rdata[RSVD_LO_BIT] &&
        rsp.rdata[BASE_MSB:BASE_LSB] == $past(base) && !rsp.undef
  ) else $error("region read returned wrong fields");

  // the enable bit follows a privileged write
  AST_ENABLE_WRITE: assert property (
    take && cp_req_i.priv && cp_req_i.write && is_region(cp_req_i)
    |=> en == ($past(cp_req_i.wdata[ENABLE_BIT]) && PRESENT)
  ) else $error("enable bit write not applied");

  // an absent memory never shows as enabled
  AST_ABSENT_EN: assert property (
    !PRESENT |-> !en && !hit
  ) else $error("enable set without a memory");

  // other encodings are answered as undefined
  AST_UNMAPPED: assert property (
    take && cp_req_i.priv && !is_region(cp_req_i) && !is_select(cp_req_i)
    |=> rsp.ack && rsp.undef
  ) else $error("unmapped encoding was accepted");

  // the selection register reads zero and ignores writes
  AST_SELECT_RAZ: assert property (
    take && cp_req_i.priv && is_select(cp_req_i)
    |=> rsp.ack && !rsp.undef && rsp.rdata == '0 && $stable(base) && $stable(en)
  ) else $error("selection register not read as zero");

  // an address inside the aligned window hits one cycle later
  AST_WINDOW_HIT: assert property (
    state == ST_RUN && mem_valid_i && en &&
    ((mem_addr_i >> WIN_SHIFT) == ({base, 12'h000} >> WIN_SHIFT)) |=> hit
  ) else $error("address inside the window did not hit");

  // an address outside the aligned window never hits
  AST_WINDOW_MISS: assert property (
    ((mem_addr_i >> WIN_SHIFT) != ({base, 12'h000} >> WIN_SHIFT)) |=> !hit
  ) else $error("address outside the window hit");

  // nothing hits while the memory is disabled
  AST_NO_HIT_OFF: assert property (
    !en || !mem_valid_i |=> !hit
  ) else $error("hit while disabled or idle");

  // a user access to the selection register is refused as well
  AST_SELECT_USER: assert property (
    take && !cp_req_i.priv && is_select(cp_req_i)
    |=> rsp.ack && rsp.undef && rsp.rdata == '0 && $stable(base)
  ) else $error("user access to the selection register was not refused");

  // a refused user access leaves the enable bit alone
  AST_USER_EN_HOLD: assert property (
    take && !cp_req_i.priv |=> $stable(en)
  ) else $error("user mode access changed the enable bit");

  // no answer and no hit appear before the straps are loaded
  AST_QUIET_INIT: assert property (
    state != ST_RUN |=> !rsp.ack && !hit
  ) else $error("answer or hit before the strap load finished");

  // without a taken request the answer word falls back to zero
  AST_RSP_IDLE: assert property (
    !take |=> rsp == '0
  ) else $error("answer shown without a taken request");

  // an answer stands for exactly one cycle unless a new request is taken
  AST_ACK_PULSE: assert property (
    rsp.ack && !$past(take) |-> 1'b0
  ) else $error("answer without a taken request");

endmodule

`default_nettype wire

// ### hw/tcr_pkg.sv
// tcr_pkg: constants and carriers for the primary tight memory region registers
// assumes one core clock domain and a coprocessor access port driven by the core
`default_nettype none

package tcr_pkg;

  // coprocessor encoding of the region register
  localparam logic [3:0] CRN_REGION   = 4'h9;
  localparam logic [3:0] CRM_REGION   = 4'h1;
  localparam logic [2:0] OP1_REGION   = 3'h0;
  localparam logic [2:0] OP2_REGION   = 3'h1;
  // coprocessor encoding of the selection register
  localparam logic [3:0] CRM_SELECT   = 4'h2;
  localparam logic [2:0] OP2_SELECT   = 3'h0;

  // field positions of the region word
  localparam int BASE_MSB    = 31;
  localparam int BASE_LSB    = 12;
  localparam int RSVD_HI_MSB = 11;
  localparam int RSVD_HI_LSB = 7;
  localparam int SIZE_MSB    = 6;
  localparam int SIZE_LSB    = 2;
  localparam int RSVD_LO_BIT = 1;
  localparam int ENABLE_BIT  = 0;

  // memory_size encodings: code n means 2^(n+9) bytes
  localparam logic [4:0] SIZE_NONE    = 5'h00;
  localparam logic [4:0] SIZE_4KB     = 5'h03;
  localparam logic [4:0] SIZE_8MB     = 5'h0e;
  localparam logic [4:0] SIZE_LOG_OFS = 5'h03;

  // values after reset
  localparam logic [19:0] RST_BASE_LOW  = 20'h00000;
  localparam logic [19:0] RST_BASE_IMPL = 20'h00000;
  localparam logic        RST_ENABLE    = 1'b0;

  // pin synchroniser depth before the strap values are loaded
  localparam int STRAP_SYNC_CYCLES = 2;

  // init sequence, gray coded
  typedef enum logic [1:0] {
    ST_SYNC0 = 2'b00,
    ST_SYNC1 = 2'b01,
    ST_LOAD  = 2'b11,
    ST_RUN   = 2'b10
  } tcr_state_t;

  // coprocessor request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [3:0]  crn;
    logic [2:0]  op1;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [31:0] wdata;
  } tcr_cp_req_t;

  // coprocessor answer to the core
  typedef struct packed {
    logic        ack;
    logic        undef;
    logic [31:0] rdata;
  } tcr_cp_rsp_t;

endpackage

`default_nettype wire

// ### dv/tcm_region_config_bench.sv
// tcm_region_config_bench: self-checking bench for tcr_region (16KB config)
// assumes tcr_pkg is compiled first; the bench alone drives every dut input
`default_nettype none

module tcm_region_config_bench import tcr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [4:0]  SZ   = 5'h05;     // 16KB so base bits 13:12 are ignored
  localparam logic [19:0] IMPL = 20'h0a5a5; // arbitrary implementation base

  // dut stimulus and observation
  logic        core_clk_i = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic        las        = 1'b1;
  logic        ien        = 1'b1;
  tcr_cp_req_t req        = '0;
  logic        ready;
  tcr_cp_rsp_t rsp;
  logic        mvalid     = 1'b0;
  logic [31:0] maddr      = 32'h0;
  logic        hit;
  logic [19:0] base;
  logic        en;
  logic        bare_en;
  tcr_cp_rsp_t bare_rsp;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  tcr_cp_rsp_t r;

  // 10 MHz core clock
  always #50 core_clk_i = ~core_clk_i;

  tcr_region #(.SIZE_CODE(SZ), .MEM_PRESENT(1'b1), .IMPL_BASE(IMPL)) i_dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .low_address_select_pin_i(las),
    .initial_enable_pin_i(ien), .cp_req_i(req), .cp_ready_o(ready), .cp_rsp_o(rsp),
    .mem_valid_i(mvalid), .mem_addr_i(maddr), .mem_hit_o(hit),
    .tcm_base_o(base), .tcm_enable_o(en));

  // same stimulus, memory absent: only the enable output and the read word matter here
  tcr_region #(.SIZE_CODE(SZ), .MEM_PRESENT(1'b0), .IMPL_BASE(IMPL)) i_bare (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .low_address_select_pin_i(las),
    .initial_enable_pin_i(ien), .cp_req_i(req), .cp_ready_o(), .cp_rsp_o(bare_rsp),
    .mem_valid_i(mvalid), .mem_addr_i(maddr), .mem_hit_o(),
    .tcm_base_o(), .tcm_enable_o(bare_en));

  function automatic logic [31:0] word(input logic [19:0] b, input logic e);
    return {b, 5'h00, SZ, 1'b0, e}; // reserved bits read as zero by design choice
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reset with given strap levels; straps settle before release
  task automatic do_reset(input logic l, input logic i);
    int k;
    rst_b_i = 1'b0;
    las = l;
    ien = i;
    repeat (16) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    for (k = 0; k < 10 && ready !== 1'b1; k++) @(posedge core_clk_i);
    if (ready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t ready never rose", $time);
      conclude();
    end
  endtask

  // one coprocessor access; answer sampled in the single cycle it stands
  task automatic cp(input logic wr, input logic pv, input logic [3:0] crm,
                    input logic [2:0] op2, input logic [31:0] wd, output tcr_cp_rsp_t o);
    @(posedge core_clk_i);
    #1 req = '{valid: 1'b1, write: wr, priv: pv, crn: CRN_REGION, op1: OP1_REGION,
               crm: crm, op2: op2, wdata: wd};
    @(posedge core_clk_i);
    #1 req.valid = 1'b0;
    o = rsp;
    check({31'h0, o.ack}, 32'h1, "ack");
  endtask

  task automatic rd_region(input logic [31:0] exp, input string msg);
    cp(1'b0, 1'b1, CRM_REGION, OP2_REGION, 32'h0, r);
    check({31'h0, r.undef}, 32'h0, msg);
    check(r.rdata, exp, msg);
  endtask

  task automatic probe(input logic [31:0] a, input logic exp);
    @(posedge core_clk_i);
    #1 mvalid = 1'b1;
    maddr = a;
    @(posedge core_clk_i);
    #1 mvalid = 1'b0;
    check({31'h0, hit}, {31'h0, exp}, "window hit");
  endtask

  task automatic t_reset_low_straps();
    do_reset(1'b1, 1'b1);
    check({12'h0, base}, 32'h0, "base after reset");
    check({31'h0, en}, 32'h1, "enable after reset");
    check({31'h0, bare_en}, 32'h0, "absent enable");
    rd_region(word(20'h0, 1'b1), "reset word");
    check(bare_rsp.rdata, 32'h0, "absent reset word");
  endtask

  task automatic t_write_fields();
    // size bits set in the write must not show; base is size aligned, reserved bits zero
    cp(1'b1, 1'b1, CRM_REGION, OP2_REGION, 32'h1234407d, r);
    check({31'h0, r.undef}, 32'h0, "write undef");
    rd_region(word(20'h12344, 1'b1), "written word");
    check(bare_rsp.rdata, 32'h12344000, "absent written word");
    check({12'h0, base}, 32'h00012344, "base out");
    check({31'h0, bare_en}, 32'h0, "absent enable after write");
  endtask

  task automatic t_window();
    probe(32'h12344abc, 1'b1);
    probe(32'h12347fff, 1'b1);
    probe(32'h12348000, 1'b0);
    probe(32'h12343fff, 1'b0);
    cp(1'b1, 1'b1, CRM_REGION, OP2_REGION, 32'h12344000, r);
    check({31'h0, en}, 32'h0, "enable cleared");
    probe(32'h12344abc, 1'b0);
    cp(1'b1, 1'b1, CRM_REGION, OP2_REGION, 32'h12344001, r);
  endtask

  task automatic t_privilege();
    cp(1'b1, 1'b0, CRM_REGION, OP2_REGION, 32'hfffff000, r);
    check({31'h0, r.undef}, 32'h1, "user write refused");
    cp(1'b0, 1'b0, CRM_REGION, OP2_REGION, 32'h0, r);
    check({31'h0, r.undef}, 32'h1, "user read refused");
    check(r.rdata, 32'h0, "user read data");
    rd_region(word(20'h12344, 1'b1), "unchanged after user");
  endtask

  task automatic t_select();
    cp(1'b1, 1'b1, CRM_SELECT, OP2_SELECT, 32'hffffffff, r);
    check({31'h0, r.undef}, 32'h0, "select write");
    cp(1'b0, 1'b1, CRM_SELECT, OP2_SELECT, 32'h0, r);
    check({31'h0, r.undef}, 32'h0, "select read");
    check(r.rdata, 32'h0, "select reads zero");
    cp(1'b0, 1'b0, CRM_SELECT, OP2_SELECT, 32'h0, r);
    check({31'h0, r.undef}, 32'h1, "select user refused");
    // neighbour encoding of the region register must not decode
    cp(1'b1, 1'b1, CRM_REGION, 3'h0, 32'h0, r);
    check({31'h0, r.undef}, 32'h1, "wrong opcode2");
    rd_region(word(20'h12344, 1'b1), "region after select");
  endtask

  task automatic t_reset_impl();
    do_reset(1'b0, 1'b0);
    check({12'h0, base}, {12'h0, IMPL}, "impl base");
    check({31'h0, en}, 32'h0, "enable strap low");
    rd_region(word(IMPL, 1'b0), "impl word");
    probe({IMPL, 12'h010}, 1'b0);
  endtask

  initial begin
    t_reset_low_straps();
    t_write_fields();
    t_window();
    t_privilege();
    t_select();
    t_reset_impl();
    conclude();
  end
endmodule

`default_nettype wire
